// ---- rtl/opp_params.svh ----
/*
  Constants of the one-time-programmable memory programming port.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef OPP_PARAMS_SVH
`define OPP_PARAMS_SVH

`define OPP_ADDR_W 16
`define OPP_DATA_W 8
`define OPP_ARRAY_WORDS 16384
`define OPP_PROM_LAST 20'h03fff
`define OPP_MCU_LOW_BASE 20'h04000
`define OPP_MCU_LOW_LAST 20'h07eff
`define OPP_MCU_HIGH_BASE 20'hfff00
`define OPP_PROM_HIGH_BASE 14'h3f00
`define OPP_BLANK 8'hff
`define OPP_PULSE_NS 100000
`define OPP_CLK_NS 25
`define OPP_MAX_PULSES 25

`endif

// ---- rtl/opp_pkg.sv ----
/*
  Types shared by the programming port.
  Assumes opp_params.svh is on the include path.
*/
`default_nettype none
`include "opp_params.svh"

package opp_pkg;
  typedef enum logic [1:0] {
    opp_idle,
    opp_read,
    opp_program
  } opp_mode_e;

  typedef struct packed {
    logic [`OPP_DATA_W-1:0] port_four_lines;
    logic [`OPP_DATA_W-1:0] port_six_lines;
  } opp_addr_s;

  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic program_strobe_n;
  } opp_ctrl_s;

  typedef struct packed {
    opp_addr_s addr_s1;
    opp_addr_s addr_s2;
    opp_addr_s addr_s3;
    opp_addr_s addr;
    logic [`OPP_DATA_W-1:0] data_s1;
    logic [`OPP_DATA_W-1:0] data_s2;
    logic [`OPP_DATA_W-1:0] data_s3;
    logic [`OPP_DATA_W-1:0] data;
    logic [2:0] ctrl_s1;
    logic [2:0] ctrl_s2;
    logic [2:0] ctrl_s3;
    opp_ctrl_s ctrl;
    opp_mode_e mode;
    logic [`OPP_DATA_W-1:0] read_data;
    logic [`OPP_DATA_W-1:0] write_data;
    logic [13:0] write_addr;
    logic [15:0] pulse_cycles;
    logic [4:0] pulse_count;
    logic write_pending;
  } opp_state_s;
endpackage : opp_pkg
`default_nettype wire

// ---- rtl/opp_port.sv ----
/*
  Programming and verify port of the on-chip one-time-programmable program array.
  Assumes an external programmer drives address, data and the active-low strobes,
  and that the device is already held in programming mode by its straps.
*/
`timescale 1ns/10ps
`default_nettype none
`include "opp_params.svh"

// Overview of operation
// - Address: high byte port four, low six
// - Data lines bidirectional: programmer writes, device reads
// - Active-low chip, output and program strobes
// - MCU addresses map onto programming window
module opp_port #(
  parameter int ADDR_W = `OPP_ADDR_W,
  parameter int DATA_W = `OPP_DATA_W,
  parameter int WORDS = `OPP_ARRAY_WORDS,
  parameter int PULSE_CYCLES = (`OPP_PULSE_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire opp_pkg::opp_addr_s prom_addr,
  input wire logic [DATA_W-1:0] prom_data_bus_in,
  output logic [DATA_W-1:0] prom_data_bus_out,
  output logic prom_data_bus_oe,
  input wire opp_pkg::opp_ctrl_s prom_ctrl,
  input wire logic [19:0] mcu_addr,
  output logic [13:0] mapped_addr,
  output logic mapped_valid,
  output logic [4:0] pulse_count,
  output logic pulse_limit
);
  // ==========================================================
  // Checks and storage
  if (DATA_W != 8 || ADDR_W != 16 || WORDS != 16384 || PULSE_CYCLES < 1 ||
      PULSE_CYCLES > 65535) begin : g_bad_params
    $error("opp_port: unsupported parameters");
  end

  // Array starts blank; a cell only loses ones, as a fused bit cannot be restored
  logic [DATA_W-1:0] array_mem [WORDS];
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      array_mem[i] = `OPP_BLANK;
    end
  end

  // Folds the MCU-mode view onto the programming window
  function automatic logic [14:0] opp_map(input logic [19:0] a);
    logic [14:0] r;
    r = 15'h0000;
    if (a >= `OPP_MCU_LOW_BASE && a <= `OPP_MCU_LOW_LAST) begin
      r = {1'b1, 14'(a - `OPP_MCU_LOW_BASE)};
    end else if (a >= `OPP_MCU_HIGH_BASE) begin
      r = {1'b1, `OPP_PROM_HIGH_BASE | 14'(a[7:0])};
    end
    return r;
  endfunction : opp_map

  // ==========================================================
  // State
  opp_pkg::opp_state_s st, next_st;
  logic [13:0] word_addr;
  logic strobe_fall, strobe_rise, quiet;

  // Upper two address lines are outside the 16 KB window and fold away
  assign word_addr = {st.addr.port_four_lines[5:0], st.addr.port_six_lines};
  assign quiet = st.ctrl_s2 == st.ctrl_s3;

  always_comb begin
    next_st = st;
    next_st.ctrl_s1 = prom_ctrl;
    next_st.ctrl_s2 = st.ctrl_s1;
    next_st.ctrl_s3 = st.ctrl_s2;
    // Address and data pins settle on the same three stages as the strobes
    next_st.addr_s1 = prom_addr;
    next_st.addr_s2 = st.addr_s1;
    next_st.addr_s3 = st.addr_s2;
    next_st.data_s1 = prom_data_bus_in;
    next_st.data_s2 = st.data_s1;
    next_st.data_s3 = st.data_s2;
    if (st.addr_s2 == st.addr_s3) begin
      next_st.addr = st.addr_s3;
    end
    if (st.data_s2 == st.data_s3) begin
      next_st.data = st.data_s3;
    end
    // Glitches on the socket must agree across two stages before counting
    if (quiet) begin
      next_st.ctrl = st.ctrl_s3;
    end
    strobe_fall = quiet && st.ctrl.program_strobe_n && !st.ctrl_s3[0];
    strobe_rise = quiet && !st.ctrl.program_strobe_n && st.ctrl_s3[0];
    next_st.write_pending = 1'b0;
    case (st.mode)
      opp_pkg::opp_idle,
      opp_pkg::opp_read: begin
        if (!st.ctrl.chip_enable_n && !st.ctrl.output_enable_n &&
            st.ctrl.program_strobe_n) begin
          next_st.mode = opp_pkg::opp_read;
        end else begin
          next_st.mode = opp_pkg::opp_idle;
        end
        if (!st.ctrl.chip_enable_n && strobe_fall) begin
          next_st.mode = opp_pkg::opp_program;
          next_st.write_addr = word_addr;
          next_st.write_data = st.data;
          next_st.pulse_cycles = 16'h0000;
          if (word_addr != st.write_addr) begin
            next_st.pulse_count = 5'h00;
          end
        end
        next_st.read_data = array_mem[word_addr];
      end
      opp_pkg::opp_program: begin
        if (st.pulse_cycles != 16'hffff) begin
          next_st.pulse_cycles = st.pulse_cycles + 16'h0001;
        end
        if (strobe_rise || st.ctrl.chip_enable_n) begin
          next_st.mode = opp_pkg::opp_idle;
          // Short pulses store nothing; the cell needs its full dose
          // The counter lags the accepted low level by one cycle
          if (st.pulse_cycles >= 16'(PULSE_CYCLES - 1) && !st.ctrl.chip_enable_n) begin
            next_st.write_pending = 1'b1;
            if (st.pulse_count != 5'(`OPP_MAX_PULSES)) begin
              next_st.pulse_count = st.pulse_count + 5'h01;
            end
          end
        end
      end
      default: begin
        next_st.mode = opp_pkg::opp_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '{ctrl_s1: 3'h7, ctrl_s2: 3'h7, ctrl_s3: 3'h7, ctrl: 3'h7,
              mode: opp_pkg::opp_idle, write_addr: 14'h0000, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Plain always: the blank image comes from the initial block above
  always @(posedge clk_sys) begin
    if (st.write_pending) begin
      array_mem[st.write_addr] <= array_mem[st.write_addr] & st.write_data;
    end
  end

  // ==========================================================
  // Outputs
  assign prom_data_bus_out = st.read_data;
  assign prom_data_bus_oe = st.mode == opp_pkg::opp_read;
  assign {mapped_valid, mapped_addr} = opp_map(mcu_addr);
  assign pulse_count = st.pulse_count;
  assign pulse_limit = st.pulse_count == 5'(`OPP_MAX_PULSES);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  oe_needs_enables_a: assert property (
    prom_data_bus_oe |-> !$past(st.ctrl.chip_enable_n) &&
    !$past(st.ctrl.output_enable_n) &&
    $past(st.ctrl.program_strobe_n))
    else $error("data bus driven without enables");
  oe_follows_enables_a: assert property (
    (st.mode != opp_pkg::opp_program && !st.ctrl.chip_enable_n &&
     !st.ctrl.output_enable_n && st.ctrl.program_strobe_n && !strobe_fall)
    |=> prom_data_bus_oe)
    else $error("data bus not driven when enabled");
  no_drive_program_a: assert property (
    st.mode == opp_pkg::opp_program |-> !prom_data_bus_oe)
    else $error("data bus driven while programming");
  short_pulse_a: assert property (
    st.write_pending |-> $past(st.pulse_cycles) >= 16'(PULSE_CYCLES - 1))
    else $error("write from short pulse");
  count_bound_a: assert property (
    st.pulse_count <= 5'(`OPP_MAX_PULSES))
    else $error("pulse count above limit");
  count_step_a: assert property (
    st.write_pending && !$past(pulse_limit, 2) |-> st.pulse_count != $past(st.pulse_count))
    else $error("pulse count stuck");
  map_low_a: assert property (
    mcu_addr == `OPP_MCU_LOW_BASE |-> mapped_valid && mapped_addr == 14'h0000)
    else $error("low region map wrong");
  map_high_a: assert property (
    mcu_addr == 20'hfffff |-> mapped_valid && mapped_addr == 14'h3fff)
    else $error("high region map wrong");
  addr_fold_a: assert property (
    word_addr[7:0] == st.addr.port_six_lines)
    else $error("low address byte lost");

  read_cov_c: cover property (!prom_data_bus_oe ##1 prom_data_bus_oe);
  write_cov_c: cover property (st.write_pending);
  limit_cov_c: cover property (pulse_limit);
  blank_read_cov_c: cover property (prom_data_bus_oe && prom_data_bus_out == 8'hff);

  strobe_low_quiet_a: assert property (
    !st.ctrl.program_strobe_n |-> !prom_data_bus_oe)
    else $error("data bus driven while strobe low");
  write_enabled_a: assert property (
    st.write_pending |-> !$past(st.ctrl.chip_enable_n))
    else $error("write without chip enable");
  abort_exit_a: assert property (
    st.mode == opp_pkg::opp_program && st.ctrl.chip_enable_n |=> !st.write_pending)
    else $error("aborted pulse still writes");
  capture_data_a: assert property (
    st.mode == opp_pkg::opp_program && $past(st.mode) != opp_pkg::opp_program
    |-> st.write_data == $past(st.data))
    else $error("program data not captured");
  map_outside_a: assert property (
    mcu_addr < `OPP_MCU_LOW_BASE |-> !mapped_valid)
    else $error("address below window mapped");
endmodule : opp_port
`default_nettype wire

// ---- tb/opp_programmer.sv ----
/* Programmer model: drives address, data and strobes of the port.
   Assumes the bench resolves the shared data lines. */
`timescale 1ns/10ps
`default_nettype none
module opp_programmer (
  input wire logic clk_sys,
  input wire logic [7:0] bus,
  input wire logic bus_oe,
  output opp_pkg::opp_addr_s addr,
  output opp_pkg::opp_ctrl_s ctrl,
  output logic [7:0] drv,
  output logic drv_oe
);
  // ====
  // Pin sequences
  initial begin
    addr = '0;
    ctrl = 3'h7;
    drv = '0;
    drv_oe = 1'b0;
  end
  task automatic pulse(input logic [15:0] a, input logic [7:0] d, input int len);
    @(posedge clk_sys);
    addr <= a;
    drv <= d;
    drv_oe <= 1'b1;
    ctrl <= 3'h3;
    repeat (6) @(posedge clk_sys);
    ctrl <= 3'h2;
    repeat (len) @(posedge clk_sys);
    ctrl <= 3'h3;
    repeat (10) @(posedge clk_sys);
    ctrl <= 3'h7;
    drv_oe <= 1'b0;
  endtask : pulse
  task automatic read(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_sys);
    addr <= a;
    ctrl <= 3'h1;
    // Bounded: a silent device must not hang the run
    for (int i = 0; i < 12 && bus_oe !== 1'b1; i++) @(negedge clk_sys);
    ok = bus_oe;
    d = bus;
    @(posedge clk_sys);
    ctrl <= 3'h5;
    repeat (8) @(posedge clk_sys);
  endtask : read
endmodule : opp_programmer
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench of the programming port.
   Assumes a short pulse parameter of 20 cycles. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [19:0] mcu_addr = '0;
  logic [7:0] bus, dout, drv, rd;
  logic [7:0] flt = 8'h00;
  logic oe, drv_oe, ok, lim, mval;
  logic [13:0] maddr;
  logic [4:0] cnt;
  opp_pkg::opp_addr_s addr;
  opp_pkg::opp_ctrl_s ctrl;
  int error_cnt = 0;
  int n_checks = 0;
  int mem[int];
  int ecnt = 0;
  int ea = -1;
  int m;
  int pts[8] = '{32'h03fff, 32'h04000, 32'h07eff, 32'h07f00, 32'hffeff, 32'hfff00,
    32'hfffff, 32'h00000};
  // ====
  // Wiring: a released bus shows the inverse of its last level
  assign bus = oe ? dout : (drv_oe ? drv : flt);
  always @(posedge clk_sys) begin
    if (oe || drv_oe) flt <= ~bus;
  end
  initial forever #12.5 clk_sys = ~clk_sys;
  opp_port #(.PULSE_CYCLES(20)) opp_port_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .prom_addr(addr), .prom_data_bus_in(bus), .prom_data_bus_out(dout),
    .prom_data_bus_oe(oe), .prom_ctrl(ctrl), .mcu_addr(mcu_addr), .mapped_addr(maddr),
    .mapped_valid(mval), .pulse_count(cnt), .pulse_limit(lim));
  opp_programmer opp_programmer_inst (.clk_sys(clk_sys), .bus(bus), .bus_oe(oe),
    .addr(addr), .ctrl(ctrl), .drv(drv), .drv_oe(drv_oe));
  // ====
  // Model and checks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  function automatic int rdm(input int a);
    return mem.exists(a) ? mem[a] : 32'hff;
  endfunction : rdm
  function automatic logic [14:0] map(input int x);
    if (x >= 32'h4000 && x <= 32'h7eff) return {1'b1, 14'(x - 32'h4000)};
    if (x >= 32'hfff00) return {1'b1, 14'(x - 32'hfff00 + 32'h3f00)};
    return 15'h0;
  endfunction : map
  task automatic prog(input int a, input int d, input int len);
    opp_programmer_inst.pulse(16'(a), 8'(d), len);
    // Any pulse on a new address restarts the count, even a short one
    if (a != ea) ecnt = 0;
    ea = a;
    if (len >= 20) begin
      mem[a] = rdm(a) & d;
      ecnt = ecnt < 25 ? ecnt + 1 : 25;
    end
    chk(cnt, ecnt);
    chk(lim, ecnt == 25);
  endtask : prog
  task automatic verify(input int a);
    opp_programmer_inst.read(16'(a), rd, ok);
    // A silent device counts as a failure; the run still ends at the verdict
    if (ok !== 1'b1) error_cnt++;
    chk(rd, rdm(a));
    chk(oe, 1'b0);
  endtask : verify
  // ====
  // Scenarios
  initial begin
    void'($urandom(32'heceff99f));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(oe, 1'b0);
    verify(0);
    verify('h3fff);
    prog(5, 0, 10);
    verify(5);
    for (int i = 0; i < 26; i++) prog('h123, $urandom, 22);
    verify('h123);
    prog(16'h2a0, 8'h5a, 19);
    verify(16'h2a0);
    prog(16'h2a0, 8'h5a, 20);
    verify(16'h2a0);
    for (int i = 0; i < 6; i++) begin
      m = $urandom_range('h3fff);
      prog(m, $urandom, 22);
      verify(m);
    end
    for (int i = 0; i < 24; i++) begin
      m = i < 8 ? pts[i] : $urandom_range(32'hfffff);
      @(posedge clk_sys);
      mcu_addr <= 20'(m);
      @(negedge clk_sys);
      chk({mval, mval ? maddr : 14'h0}, map(m));
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
